// *** verilog/ntmt_consts.svh ***
`ifndef NTMT_CONSTS_SVH
`define NTMT_CONSTS_SVH
// test-mode pin codes
`define NTMT_CODE_INPUT_TREE 4'h3
`define NTMT_CODE_BIDI_TREE  4'h4
// timing figures and derived counts
`define NTMT_CLK_MHZ         200
`define NTMT_REF_MHZ         30
`define NTMT_I2C_PHASE_NS    5066
`define NTMT_I2C_PHASE_CYC   (((`NTMT_I2C_PHASE_NS * `NTMT_CLK_MHZ) + 999) / 1000)
`define NTMT_REF_DIV_CYC     ((`NTMT_CLK_MHZ + `NTMT_REF_MHZ - 1) / `NTMT_REF_MHZ)
`define NTMT_RESET_HOLD_US   1000
// widths
`define NTMT_GPIO_W          10
`define NTMT_DD_W            16
`define NTMT_OUT_W           15
`define NTMT_IN_W            12
`endif

// *** verilog/ntmt_pkg.sv ***
package ntmt_pkg;
  typedef enum logic [1:0] {
    NTMT_MODE_NORMAL,
    NTMT_MODE_INPUT_TREE,
    NTMT_MODE_BIDI_TREE
  } ntmt_mode_t;
  typedef enum {
    NTMT_I2C_IDLE,
    NTMT_I2C_START,
    NTMT_I2C_LOW,
    NTMT_I2C_HIGH,
    NTMT_I2C_STOP
  } ntmt_i2c_st_t;
endpackage

// *** verilog/ntmt_top.sv ***
`timescale 1ns/100ps
`include "ntmt_consts.svh"
module ntmt_top
  import ntmt_pkg::*;
#(
  parameter int GPIO_W = `NTMT_GPIO_W,
  parameter int DD_W   = `NTMT_DD_W
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  // test mode pins
  input  wire logic [3:0]        test_mode_i,
  // two-way pins (oe low while driving)
  input  wire logic [GPIO_W-1:0] gpio_i,
  output logic      [GPIO_W-1:0] gpio_o,
  output logic      [GPIO_W-1:0] gpio_oe_n_o,
  input  wire logic [DD_W-1:0]   dd_i,
  output logic      [DD_W-1:0]   dd_o,
  output logic      [DD_W-1:0]   dd_oe_n_o,
  // plain inputs
  input  wire logic              drive_port_enable_i,
  input  wire logic              drive_power_good_i,
  input  wire logic              disk_present_ready_i,
  input  wire logic              chain_in_i,
  // functional output values
  input  wire logic [1:0]        func_led_i,
  input  wire logic              func_power_sel_i,
  input  wire logic              func_drive_reset_i,
  input  wire logic [1:0]        func_strobe_i,
  input  wire logic              func_dmack_i,
  input  wire logic [1:0]        func_cs_i,
  input  wire logic [2:0]        func_addr_i,
  input  wire logic              func_low_power_i,
  // vendor request port
  input  wire logic              load_test_outputs_request_i,
  input  wire logic              test_mode_enable_i,
  input  wire logic [15:0]       test_out_data_i,
  input  wire logic              read_test_inputs_request_i,
  output logic      [15:0]       test_in_data_o,
  output logic                   test_in_valid_o,
  // serial memory master
  input  wire logic              i2c_go_i,
  output logic                   i2c_scl_o,
  output logic                   i2c_busy_o,
  // pio mode select
  input  wire logic [2:0]        drive_pio_mode_i,
  input  wire logic              drive_pio_valid_i,
  input  wire logic [2:0]        cfg_pio_mode_i,
  input  wire logic              cfg_pio_force_i,
  output logic      [2:0]        pio_mode_o,
  // output-only pins
  output logic      [1:0]        led_outputs_n_o,
  output logic                   high_power_select_n_o,
  output logic                   drive_reset_n_o,
  output logic      [1:0]        strobe_n_o,
  output logic                   dmack_n_o,
  output logic                   pullup_source_enable_o,
  output logic                   pulldown_sink_enable_o,
  output logic      [1:0]        cs_n_o,
  output logic      [2:0]        addr_o,
  output logic                   low_power_out_n_o,
  output logic                   tree_out_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // external reset width is the board's job; we only deglitch release
  logic [1:0] rst_sync_ff;
  logic       rst_n;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // mode decode and chain
  // ----------------------------------------------------------------
  logic bidi_mode;
  logic in_mode;
  assign bidi_mode = (test_mode_i == `NTMT_CODE_BIDI_TREE);
  assign in_mode   = (test_mode_i == `NTMT_CODE_INPUT_TREE);

  // chain order: gpio 0..9 then dd 15,0,14,1,...,8,7
  localparam int CH_N = GPIO_W + DD_W;
  logic [CH_N-1:0] chain_vec;
  logic [CH_N:0]   nand_stage;
  genvar g;
  generate
    for (g = 0; g < GPIO_W; g++) begin : g_gpio
      assign chain_vec[g] = gpio_i[g];
    end
    for (g = 0; g < DD_W; g++) begin : g_dd
      if (g % 2 == 0) begin : g_hi
        assign chain_vec[GPIO_W+g] = dd_i[DD_W-1-g/2];
      end else begin : g_lo
        assign chain_vec[GPIO_W+g] = dd_i[g/2];
      end
    end
    // nand ladder: each stage is forced high when its input drops, else passes the stage before
    assign nand_stage[0] = 1'b0;
    for (g = 0; g < CH_N; g++) begin : g_nand
      assign nand_stage[g+1] = ~(chain_vec[g] & ~nand_stage[g]);
    end
  endgenerate
  // all ones gives 1; purely combinational to pads
  logic bidi_res;
  assign bidi_res = ~nand_stage[CH_N];

  // ----------------------------------------------------------------
  // input synchronisers and sampling
  // ----------------------------------------------------------------
  logic [`NTMT_IN_W-1:0] in_raw;
  logic [`NTMT_IN_W-1:0] in_s1_ff;
  logic [`NTMT_IN_W-1:0] in_s2_ff;
  assign in_raw = {chain_in_i, disk_present_ready_i, drive_power_good_i,
                   drive_port_enable_i, gpio_i[7:0]};
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_ff <= '0;
      in_s2_ff <= '0;
    end else begin
      in_s1_ff <= in_raw;
      in_s2_ff <= in_s1_ff;
    end
  end
  logic en_s;
  logic pgood_s;
  logic ready_s;
  assign en_s    = in_s2_ff[8];
  assign pgood_s = in_s2_ff[9];
  assign ready_s = in_s2_ff[10];

  // ----------------------------------------------------------------
  // manufacturing test state
  // ----------------------------------------------------------------
  logic        mfg_ff;
  logic        nxt_mfg;
  logic [15:0] mfg_val_ff;
  logic [15:0] nxt_mfg_val;
  logic [15:0] tin_ff;
  logic [15:0] nxt_tin;
  logic        tvld_ff;
  logic        nxt_tvld;
  always_comb begin
    nxt_mfg     = mfg_ff;
    nxt_mfg_val = mfg_val_ff;
    nxt_tin     = tin_ff;
    nxt_tvld    = 1'b0;
    if (load_test_outputs_request_i) begin
      nxt_mfg     = test_mode_enable_i;
      nxt_mfg_val = test_out_data_i;
    end
    if (read_test_inputs_request_i) begin
      nxt_tin  = {4'h0, in_s2_ff};
      nxt_tvld = 1'b1;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mfg_ff     <= 1'b0;
      mfg_val_ff <= 16'hffff;
      tin_ff     <= 16'h0000;
      tvld_ff    <= 1'b0;
    end else begin
      mfg_ff     <= nxt_mfg;
      mfg_val_ff <= nxt_mfg_val;
      tin_ff     <= nxt_tin;
      tvld_ff    <= nxt_tvld;
    end
  end
  assign test_in_data_o  = tin_ff;
  assign test_in_valid_o = tvld_ff;

  // ----------------------------------------------------------------
  // serial memory clock timing
  // ----------------------------------------------------------------
  // phase count from the ns figure at our clock rate, rounded up
  localparam int PH = `NTMT_I2C_PHASE_CYC;
  localparam int PW = $clog2(PH + 1);
  localparam int BITS = 9;
  ntmt_i2c_st_t i2c_st_ff;
  ntmt_i2c_st_t nxt_i2c_st;
  logic [PW-1:0] ph_ff;
  logic [PW-1:0] nxt_ph;
  logic [3:0]    bit_ff;
  logic [3:0]    nxt_bit;
  logic          scl_ff;
  logic          nxt_scl;
  always_comb begin
    nxt_i2c_st = i2c_st_ff;
    nxt_ph     = ph_ff;
    nxt_bit    = bit_ff;
    nxt_scl    = scl_ff;
    if (ph_ff != '0) begin
      nxt_ph = ph_ff - 1'b1;
    end else begin
      case (i2c_st_ff)
        NTMT_I2C_IDLE: begin
          if (i2c_go_i) begin
            nxt_i2c_st = NTMT_I2C_START; // start hold
            nxt_ph     = PW'(PH - 1);
            nxt_bit    = 4'h0;
          end
        end
        NTMT_I2C_START: begin
          nxt_i2c_st = NTMT_I2C_LOW;
          nxt_scl    = 1'b0;
          nxt_ph     = PW'(PH - 1);
        end
        NTMT_I2C_LOW: begin
          nxt_i2c_st = NTMT_I2C_HIGH;
          nxt_scl    = 1'b1;
          nxt_ph     = PW'(PH - 1);
        end
        NTMT_I2C_HIGH: begin
          nxt_ph = PW'(PH - 1);
          if (bit_ff == 4'(BITS - 1)) begin
            nxt_i2c_st = NTMT_I2C_STOP; // bus free time
          end else begin
            nxt_i2c_st = NTMT_I2C_LOW;
            nxt_scl    = 1'b0;
            nxt_bit    = bit_ff + 1'b1;
          end
        end
        NTMT_I2C_STOP: begin
          nxt_i2c_st = NTMT_I2C_IDLE;
        end
        default: begin
          nxt_i2c_st = NTMT_I2C_IDLE;
          nxt_scl    = 1'b1;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      i2c_st_ff <= NTMT_I2C_IDLE;
      ph_ff     <= '0;
      bit_ff    <= 4'h0;
      scl_ff    <= 1'b1;
    end else begin
      i2c_st_ff <= nxt_i2c_st;
      ph_ff     <= nxt_ph;
      bit_ff    <= nxt_bit;
      scl_ff    <= nxt_scl;
    end
  end

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  // functional path is registered; tree path bypasses flops on purpose
  logic [`NTMT_OUT_W-1:0] out_ff;
  logic [`NTMT_OUT_W-1:0] nxt_out;
  logic [2:0]             pio_ff;
  logic [2:0]             nxt_pio;
  logic                   busy_ff;
  always_comb begin
    // order: led1..0, pwr, rst, strobe1..0, dmack, pu, pd, cs1..0, addr2..0, lowpwr
    nxt_out = {func_led_i, func_power_sel_i, func_drive_reset_i, func_strobe_i,
               func_dmack_i, en_s & pgood_s & ready_s,
               ~(en_s & pgood_s & ready_s), func_cs_i, func_addr_i,
               func_low_power_i};
    if (mfg_ff) begin
      nxt_out = mfg_val_ff[`NTMT_OUT_W-1:0];
    end
    nxt_pio = (cfg_pio_force_i || !drive_pio_valid_i) ? cfg_pio_mode_i
                                                       : drive_pio_mode_i;
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      out_ff  <= {`NTMT_OUT_W{1'b1}};
      pio_ff  <= 3'h0;
      busy_ff <= 1'b0;
    end else begin
      out_ff  <= nxt_out;
      pio_ff  <= nxt_pio;
      busy_ff <= (nxt_i2c_st != NTMT_I2C_IDLE);
    end
  end
  assign pio_mode_o = pio_ff;
  assign i2c_busy_o = busy_ff;
  assign tree_out_o = bidi_res;

  logic [`NTMT_OUT_W-1:0] pin_v;
  assign pin_v = bidi_mode ? {`NTMT_OUT_W{bidi_res}} : out_ff;
  assign {led_outputs_n_o, high_power_select_n_o, drive_reset_n_o, strobe_n_o,
          dmack_n_o, pullup_source_enable_o, pulldown_sink_enable_o, cs_n_o,
          addr_o, low_power_out_n_o} = pin_v;
  assign i2c_scl_o = bidi_mode ? bidi_res : scl_ff;

  // two-way pins: released in bidi tree; in input tree gpio drive 0 and dd stay released
  assign gpio_o      = {GPIO_W{1'b0}};
  assign gpio_oe_n_o = {GPIO_W{~in_mode}};
  assign dd_o        = {DD_W{1'b0}};
  assign dd_oe_n_o   = {DD_W{1'b1}};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // pull condition as one net so the checks sample a plain signal
  logic pull_on;
  assign pull_on = en_s & pgood_s & ready_s;
  chk_bidi_pins_out: assert property (@(posedge clk_i) disable iff (!rst_n)
    bidi_mode |-> (addr_o == {3{bidi_res}}) && (cs_n_o == {2{bidi_res}}))
    else $error("output pins do not follow tree result");
  chk_bidi_released: assert property (@(posedge clk_i) disable iff (!rst_n)
    bidi_mode |-> (&gpio_oe_n_o) && (&dd_oe_n_o))
    else $error("two-way pin driven in bidi tree");
  chk_all_ones_one: assert property (@(posedge clk_i) disable iff (!rst_n)
    (&chain_vec) |-> bidi_res)
    else $error("all-ones chain not one");
  chk_first_low_flip: assert property (@(posedge clk_i) disable iff (!rst_n)
    (chain_vec == {{(CH_N-1){1'b1}}, 1'b0}) |-> !bidi_res)
    else $error("first input low did not toggle");
  chk_step_toggle: assert property (@(posedge clk_i) disable iff (!rst_n)
    ($past(chain_vec) != chain_vec) && ($countones($past(chain_vec) ^ chain_vec) == 1)
    && ($past(bidi_mode) && bidi_mode) |-> ($past(bidi_res) != bidi_res))
    else $error("single input change did not toggle");
  chk_mfg_out_load: assert property (@(posedge clk_i) disable iff (!rst_n)
    (load_test_outputs_request_i && test_mode_enable_i && !bidi_mode)
    ##1 !bidi_mode |-> ##1 (pin_v == $past(test_out_data_i[`NTMT_OUT_W-1:0], 2)))
    else $error("test output values not applied");
  chk_mfg_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
    mfg_ff && $stable(mfg_val_ff) && !load_test_outputs_request_i
    |=> (out_ff == $past(mfg_val_ff[`NTMT_OUT_W-1:0])))
    else $error("functional logic reached pins in test mode");
  chk_read_sample: assert property (@(posedge clk_i) disable iff (!rst_n)
    read_test_inputs_request_i |=> test_in_valid_o
    && (test_in_data_o[11:0] == $past(in_s2_ff)))
    else $error("input sample not returned");
  chk_scl_phase: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(scl_ff) |-> scl_ff [*8])
    else $error("serial clock high phase too short");
  // tree mode owns the pins, so the pull check stands aside there
  chk_pull_enable: assert property (@(posedge clk_i) disable iff (!rst_n)
    !mfg_ff && !bidi_mode && !$past(load_test_outputs_request_i)
    |=> bidi_mode || ((pullup_source_enable_o == $past(pull_on))
    && (pulldown_sink_enable_o == !$past(pull_on))))
    else $error("pull enable mismatch");

endmodule

// *** dv/ntmt_tester.sv ***
`timescale 1ns/100ps
module ntmt_tester (
  // step control
  input  wire logic        low_en_i,
  input  wire logic [4:0]  low_idx_i,
  // pad drive
  output logic      [9:0]  gpio_o,
  output logic      [15:0] dd_o
);
  // ----------------------------------------
  // chain stepping: one input low at a time
  // ----------------------------------------
  always_comb begin
    int j;
    j = int'(low_idx_i) - 10;
    gpio_o = 10'h3ff;
    dd_o   = 16'hffff;
    if (low_en_i) begin
      if (low_idx_i < 5'd10) begin
        gpio_o[low_idx_i] = 1'b0;
      end else if (j % 2 == 0) begin
        dd_o[15 - j / 2] = 1'b0;
      end else begin
        dd_o[(j - 1) / 2] = 1'b0;
      end
    end
  end
endmodule

// *** dv/test_ntmt_top.sv ***
`timescale 1ns/100ps
`include "ntmt_consts.svh"
module test_ntmt_top;
  import ntmt_pkg::*;
  localparam int PH = `NTMT_I2C_PHASE_CYC;
  logic clk_i, nrst_i, tst_on, low_en, en, good, rdy, cin, ld, me, rd, go, dv, cf, pu, pd, hp;
  logic dr, dm, lp, scl, busy, val, tro;
  logic [1:0]  led, stb, cs, fl, fs, fc;
  logic [2:0]  addr, fa, dm3, cm3, pio;
  logic [3:0]  test_mode_i;
  logic [4:0]  low_idx;
  logic [9:0]  gpio_i, g_rnd, pad_g, goe;
  logic [15:0] dd_i, pad_d, doe, tdat, tin;
  logic [14:0] pins;
  logic [31:0] seed;
  logic [3:0]  fb;
  int bad_count, checks_done, n, lo, hi;
  assign pins = {led, hp, dr, stb, dm, pu, pd, cs, addr, lp};
  assign gpio_i = tst_on ? pad_g : g_rnd;
  assign dd_i = pad_d;
  ntmt_tester ntmt_tester_i (.low_en_i(low_en), .low_idx_i(low_idx), .gpio_o(pad_g),
    .dd_o(pad_d));
  ntmt_top ntmt_top_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .test_mode_i(test_mode_i), .gpio_i(gpio_i),
    .gpio_o(), .gpio_oe_n_o(goe), .dd_i(dd_i), .dd_o(), .dd_oe_n_o(doe),
    .drive_port_enable_i(en), .drive_power_good_i(good), .disk_present_ready_i(rdy),
    .chain_in_i(cin), .func_led_i(fl), .func_power_sel_i(fb[0]),
    .func_drive_reset_i(fb[1]), .func_strobe_i(fs), .func_dmack_i(fb[2]),
    .func_cs_i(fc), .func_addr_i(fa), .func_low_power_i(fb[3]),
    .load_test_outputs_request_i(ld), .test_mode_enable_i(me), .test_out_data_i(tdat),
    .read_test_inputs_request_i(rd), .test_in_data_o(tin), .test_in_valid_o(val),
    .i2c_go_i(go), .i2c_scl_o(scl), .i2c_busy_o(busy), .drive_pio_mode_i(dm3),
    .drive_pio_valid_i(dv), .cfg_pio_mode_i(cm3), .cfg_pio_force_i(cf), .pio_mode_o(pio),
    .led_outputs_n_o(led), .high_power_select_n_o(hp), .drive_reset_n_o(dr),
    .strobe_n_o(stb), .dmack_n_o(dm), .pullup_source_enable_o(pu),
    .pulldown_sink_enable_o(pd), .cs_n_o(cs), .addr_o(addr), .low_power_out_n_o(lp),
    .tree_out_o(tro));
  function automatic logic [31:0] lfsr_nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // -----------------------------------------
  // compare helpers and shared steps
  // -----------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      bad_count++;
      $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic rnd();
    repeat (5) seed = lfsr_nx(seed);
    {fl, fs, fc, fa, dm3, cm3} <= seed[30:16];
    fb <= seed[3:0];
  endtask
  // output-only pins must all carry the combinational chain result
  task automatic tree_chk(input logic e);
    @(negedge clk_i);
    cmp({pins, scl}, {16{e}});
    cmp({15'h0, tro}, {15'h0, e});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    close_out();
  end
  // -----------------------------------------
  // main sequence
  // -----------------------------------------
  initial begin
    {nrst_i, tst_on, low_en, en, good, rdy, cin, ld, me, rd, go, dv, cf} = '0;
    {test_mode_i, low_idx, g_rnd, tdat, fl, fs, fc, fa, dm3, cm3, fb} = '0;
    seed = 32'hc66b19f5;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    test_mode_i <= `NTMT_CODE_BIDI_TREE;
    tst_on <= 1'b1;
    @(negedge clk_i);
    cmp({6'h0, goe}, 16'h03ff);
    cmp(doe, 16'hffff);
    tree_chk(1'b1);
    for (int k = 0; k < 26; k++) begin
      @(posedge clk_i);
      low_idx <= 5'(k);
      low_en <= 1'b1;
      tree_chk(1'b0);
      @(posedge clk_i);
      low_en <= 1'b0;
      tree_chk(1'b1);
    end
    @(posedge clk_i);
    test_mode_i <= `NTMT_CODE_INPUT_TREE;
    tst_on <= 1'b0;
    @(negedge clk_i);
    cmp({6'h0, goe}, 16'h0000);
    @(posedge clk_i);
    test_mode_i <= 4'h0;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_i);
      rnd();
      ld <= 1'b1;
      me <= (k < 4);
      tdat <= seed[15:0];
      @(posedge clk_i);
      ld <= 1'b0;
      repeat (3) begin
        rnd();
        @(posedge clk_i);
      end
      @(negedge clk_i);
      if (k < 4) cmp({1'b0, pins}, {1'b0, tdat[14:0]});
      else cmp({1'b0, pins}, {1'b0, fl, fb[0], fb[1], fs, fb[2], 2'b01, fc, fa, fb[3]});
    end
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_i);
      {en, good, rdy} <= 3'(c);
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      cmp({14'h0, pu, pd}, {14'h0, &c[2:0], ~&c[2:0]});
    end
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_i);
      rnd();
      g_rnd <= seed[9:0];
      {en, good, rdy, cin} <= seed[13:10];
      repeat (4) @(posedge clk_i);
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      n = 0;
      while (val !== 1'b1 && n < 8) begin
        @(negedge clk_i);
        n++;
      end
      cmp({15'h0, val}, 16'h0001);
      cmp(tin, {4'h0, cin, rdy, good, en, g_rnd[7:0]});
    end
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_i);
      rnd();
      {cf, dv} <= 2'(c);
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      cmp({13'h0, pio}, {13'h0, (cf || !dv) ? cm3 : dm3});
    end
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    while (scl !== 1'b0 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    // start hold seen from the go edge, one negedge of sampling offset
    cmp_cnt(n, PH + 1);
    lo = 0;
    while (scl === 1'b0 && lo < 3000) begin
      @(negedge clk_i);
      lo++;
    end
    hi = 0;
    while (scl === 1'b1 && hi < 3000) begin
      @(negedge clk_i);
      hi++;
    end
    cmp_cnt(lo, PH);
    cmp_cnt(hi, PH);
    n = 0;
    while (busy !== 1'b0 && n < 30000) begin
      @(negedge clk_i);
      n++;
    end
    // eight more bits of low and high, then the free time before idle
    cmp_cnt(n, 17 * PH);
    cmp({15'h0, scl}, 16'h0001);
    close_out();
  end
endmodule
